// file: hdl/tncd_core.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - token timer expiry sets self reconfig bit
// - line transition sets receive activity bit
// - foreign token sets token seen bit
// - cancel send frees transmitter on token
// - cancel listen inhibits receiver on token
// - reception underway finishes despite cancel
// - arm send picks page for token
// - arm send clears free and acked
// - transmit completion sets free flag
// - acked flag set no later than free rises
// - arm listen clears inhibit, selects page
// - broadcast accepted only with b set
// - good reception sets inhibit flag
// - length command selects long or short
// - flag wipe clears power-up and rebuild
// - diagnostic read or reset clears bits
// - line idle timeout sets rebuild flag
module tncd_core (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       soft_rst,
   input  wire logic       cmd_wr,
   input  wire logic [7:0] cmd_data,
   input  wire logic       diag_rd,
   output var  logic [7:0] diag_data,
   input  wire logic       line_input,
   input  wire logic       token_timer_expired,
   input  wire logic       line_idle_expired,
   input  wire logic       foreign_token_seen,
   input  wire logic       token_received,
   input  wire logic       tx_done,
   input  wire logic       tx_ack_received,
   input  wire logic       rx_in_progress,
   input  wire logic       rx_good,
   input  wire logic [7:0] rx_dest_id,
   output var  logic       tx_pending,
   output var  logic [1:0] tx_page,
   output var  logic       rx_enabled,
   output var  logic [1:0] rx_page,
   output var  logic       rx_accept,
   output var  logic       accept_broadcast,
   output var  logic       long_packets,
   output var  logic       tx_free_flag,
   output var  logic       tx_acked_flag,
   output var  logic       rx_inhibited_flag,
   output var  logic       power_up_flag,
   output var  logic       net_rebuild_flag
);
   // -----------------------------------------------------------------
   // command decode
   // -----------------------------------------------------------------
   tncd_cmd_if cmd_bus ();
   assign cmd_bus.strobe = cmd_wr;
   assign cmd_bus.code   = cmd_data;

   logic is_cancel_send;
   logic is_cancel_listen;
   logic is_arm_send;
   logic is_arm_listen;
   logic is_pkt_len;
   logic is_flag_wipe;

   // chaining acks carry no meaning without the chaining engine
   tncd_cmd_decode u_dec (
      .cmd              (cmd_bus),
      .is_cancel_send   (is_cancel_send),
      .is_cancel_listen (is_cancel_listen),
      .is_arm_send      (is_arm_send),
      .is_arm_listen    (is_arm_listen),
      .is_pkt_len       (is_pkt_len),
      .is_flag_wipe     (is_flag_wipe),
      .is_chain_ack     ()
   );

   wire logic any_rst = sys_rst || soft_rst;

   // both arm commands carry the page in one field
   function automatic logic [1:0] page_field(input logic [7:0] code);
      return code[tncd_pkg::PAGE_MSB:tncd_pkg::PAGE_LSB];
   endfunction

   // -----------------------------------------------------------------
   // transmit side
   // -----------------------------------------------------------------
   logic       tx_pend_q;
   logic       tx_pend_d;
   logic       tx_active_q;
   logic       tx_active_d;
   logic       tx_cancel_q;
   logic       tx_cancel_d;
   logic       tx_free_q;
   logic       tx_free_d;
   logic       tx_acked_q;
   logic       tx_acked_d;
   logic [1:0] tx_page_q;
   logic [1:0] tx_page_d;

   wire logic tx_start = tx_pend_q && token_received;

   always_comb begin
      tx_pend_d   = tx_pend_q;
      tx_active_d = tx_active_q;
      tx_cancel_d = tx_cancel_q;
      tx_free_d   = tx_free_q;
      tx_acked_d  = tx_acked_q;
      tx_page_d   = tx_page_q;
      if (tx_start) begin
         tx_pend_d   = 1'b0;
         tx_active_d = 1'b1;
      end
      if (tx_active_q && tx_ack_received) begin
         tx_acked_d = 1'b1;
      end
      if (tx_active_q && tx_done) begin
         tx_active_d = 1'b0;
         tx_free_d   = 1'b1;
         // ack arriving with done still counts, set in the same cycle free rises
         tx_acked_d  = tx_acked_q || tx_ack_received;
      end
      if (tx_cancel_q && token_received) begin
         tx_cancel_d = 1'b0;
         tx_free_d   = 1'b1;
      end
      if (is_cancel_send) begin
         tx_pend_d   = 1'b0;
         tx_cancel_d = 1'b1;
      end
      if (is_arm_send) begin
         tx_page_d   = page_field(cmd_data);
         tx_pend_d   = 1'b1;
         tx_cancel_d = 1'b0;
         tx_free_d   = 1'b0;
         tx_acked_d  = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (any_rst) begin
         tx_pend_q   <= 1'b0;
         tx_active_q <= 1'b0;
         tx_cancel_q <= 1'b0;
         tx_free_q   <= 1'b1;
         tx_acked_q  <= 1'b0;
         tx_page_q   <= 2'h0;
      end else begin
         tx_pend_q   <= tx_pend_d;
         tx_active_q <= tx_active_d;
         tx_cancel_q <= tx_cancel_d;
         tx_free_q   <= tx_free_d;
         tx_acked_q  <= tx_acked_d;
         tx_page_q   <= tx_page_d;
      end
   end

   // -----------------------------------------------------------------
   // receive side
   // -----------------------------------------------------------------
   logic       rx_en_q;
   logic       rx_en_d;
   logic       rx_cancel_q;
   logic       rx_cancel_d;
   logic       rx_inh_q;
   logic       rx_inh_d;
   logic       bcast_q;
   logic       bcast_d;
   logic [1:0] rx_page_q;
   logic [1:0] rx_page_d;

   always_comb begin
      rx_en_d     = rx_en_q;
      rx_cancel_d = rx_cancel_q;
      rx_inh_d    = rx_inh_q;
      bcast_d     = bcast_q;
      rx_page_d   = rx_page_q;
      if (rx_en_q && rx_good) begin
         rx_en_d  = 1'b0;
         rx_inh_d = 1'b1;
      end
      // a cancel waits out a packet already underway
      if (rx_cancel_q && token_received && !rx_in_progress) begin
         rx_cancel_d = 1'b0;
         rx_en_d     = 1'b0;
         rx_inh_d    = 1'b1;
      end
      if (is_cancel_listen) begin
         rx_cancel_d = 1'b1;
      end
      if (is_arm_listen) begin
         rx_en_d     = 1'b1;
         rx_cancel_d = 1'b0;
         rx_inh_d    = 1'b0;
         rx_page_d   = page_field(cmd_data);
         bcast_d     = cmd_data[tncd_pkg::BCAST_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (any_rst) begin
         rx_en_q     <= 1'b0;
         rx_cancel_q <= 1'b0;
         rx_inh_q    <= 1'b1;
         bcast_q     <= 1'b0;
         rx_page_q   <= 2'h0;
      end else begin
         rx_en_q     <= rx_en_d;
         rx_cancel_q <= rx_cancel_d;
         rx_inh_q    <= rx_inh_d;
         bcast_q     <= bcast_d;
         rx_page_q   <= rx_page_d;
      end
   end

   // -----------------------------------------------------------------
   // packet acceptance
   // -----------------------------------------------------------------
   wire logic is_bcast = (rx_dest_id == tncd_pkg::BCAST_ID);
   assign rx_accept = rx_en_q && (!is_bcast || bcast_q);

   // -----------------------------------------------------------------
   // configuration and system flags
   // -----------------------------------------------------------------
   logic long_q;
   logic por_q;
   logic rebuild_q;

   always_ff @(posedge clock) begin
      if (any_rst) begin
         long_q <= 1'b0;
      end else if (is_pkt_len) begin
         long_q <= cmd_data[tncd_pkg::LONG_BIT];
      end
   end

   // reset itself raises the power-up flag
   always_ff @(posedge clock) begin
      if (any_rst) begin
         por_q <= 1'b1;
      end else if (is_flag_wipe && cmd_data[tncd_pkg::WIPE_POR_BIT]) begin
         por_q <= 1'b0;
      end
   end

   // a timeout in the wipe cycle wins over the clear
   always_ff @(posedge clock) begin
      if (any_rst) begin
         rebuild_q <= 1'b0;
      end else if (line_idle_expired) begin
         rebuild_q <= 1'b1;
      end else if (is_flag_wipe && cmd_data[tncd_pkg::WIPE_REBUILD_BIT]) begin
         rebuild_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // diagnostic status
   // -----------------------------------------------------------------
   logic       line_prev_q;
   logic       self_rebuild_q;
   logic       rx_act_q;
   logic       tok_seen_q;
   logic [7:0] diag_word;

   wire logic line_edge = line_input ^ line_prev_q;

   // follows the line through reset too, so release brings no false edge
   always_ff @(posedge clock) begin
      line_prev_q <= line_input;
   end

   // set beats the read-clear so no event is lost
   always_ff @(posedge clock) begin
      if (any_rst) begin
         self_rebuild_q <= 1'b0;
         rx_act_q       <= 1'b0;
         tok_seen_q     <= 1'b0;
      end else begin
         self_rebuild_q <= token_timer_expired || (self_rebuild_q && !diag_rd);
         rx_act_q       <= line_edge || (rx_act_q && !diag_rd);
         tok_seen_q     <= foreign_token_seen || (tok_seen_q && !diag_rd);
      end
   end

   // undefined bits stay at the cleared level
   always_comb begin
      diag_word                              = tncd_pkg::DIAG_RESET;
      diag_word[tncd_pkg::DIAG_SELF_REBUILD] = self_rebuild_q;
      diag_word[tncd_pkg::DIAG_RX_ACT]       = rx_act_q;
      diag_word[tncd_pkg::DIAG_FOREIGN_TOK]  = tok_seen_q;
   end

   // read data is a flop, valid the cycle after diag_rd
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         diag_data <= tncd_pkg::DIAG_RESET;
      end else if (diag_rd) begin
         diag_data <= diag_word;
      end
   end

   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   // both page outputs are two bits, so the field must be too
   if (tncd_pkg::PAGE_MSB - tncd_pkg::PAGE_LSB != 1) begin : g_page_chk
      $error("page field width does not fit the page outputs");
   end
   // the opcode compare is three bits wide
   if (tncd_pkg::OP_MSB - tncd_pkg::OP_LSB != 2) begin : g_op_chk
      $error("opcode field width does not fit the decoder");
   end
   // broadcast flag and page share the arm listen code
   if (tncd_pkg::BCAST_BIT <= tncd_pkg::PAGE_MSB) begin : g_bcast_chk
      $error("broadcast bit overlaps the page field");
   end
   // one wipe write may clear both flags, so the selects must differ
   if (tncd_pkg::WIPE_POR_BIT == tncd_pkg::WIPE_REBUILD_BIT) begin : g_wipe_chk
      $error("flag wipe selects share one bit");
   end
   // a diagnostic bit placed twice would hide an event
   if (tncd_pkg::DIAG_SELF_REBUILD == tncd_pkg::DIAG_RX_ACT
       || tncd_pkg::DIAG_RX_ACT == tncd_pkg::DIAG_FOREIGN_TOK
       || tncd_pkg::DIAG_SELF_REBUILD == tncd_pkg::DIAG_FOREIGN_TOK) begin : g_diag_chk
      $error("diagnostic bit positions collide");
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign tx_pending        = tx_pend_q;
   assign tx_page           = tx_page_q;
   assign rx_enabled        = rx_en_q;
   assign rx_page           = rx_page_q;
   assign accept_broadcast  = bcast_q;
   assign long_packets      = long_q;
   assign tx_free_flag      = tx_free_q;
   assign tx_acked_flag     = tx_acked_q;
   assign rx_inhibited_flag = rx_inh_q;
   assign power_up_flag     = por_q;
   assign net_rebuild_flag  = rebuild_q;
endmodule
`default_nettype wire

// file: hdl/tncd_pkg.sv
package tncd_pkg;
   // -----------------------------------------------------------------
   // command codes and field positions
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_CHAIN_TX_ACK = 8'h00;
   localparam logic [7:0] CMD_CANCEL_SEND  = 8'h01;
   localparam logic [7:0] CMD_CANCEL_LISTN = 8'h02;
   localparam logic [7:0] CMD_CHAIN_RX_ACK = 8'h08;
   localparam logic [2:0] OP_ARM_SEND      = 3'h3;
   localparam logic [2:0] OP_ARM_LISTEN    = 3'h4;
   localparam logic [2:0] OP_PKT_LEN       = 3'h5;
   localparam logic [2:0] OP_FLAG_WIPE     = 3'h6;
   localparam int         OP_LSB           = 0;
   localparam int         OP_MSB           = 2;
   localparam int         PAGE_LSB         = 3;
   localparam int         PAGE_MSB         = 4;
   localparam int         BCAST_BIT        = 7;
   localparam logic [7:0] BCAST_ID         = 8'h00;
   localparam int         LONG_BIT         = 3;
   localparam int         WIPE_POR_BIT     = 3;
   localparam int         WIPE_REBUILD_BIT = 4;
   // -----------------------------------------------------------------
   // diagnostic register layout and short packet limit
   // -----------------------------------------------------------------
   localparam int         DIAG_SELF_REBUILD = 7;
   localparam int         DIAG_RX_ACT      = 5;
   localparam int         DIAG_FOREIGN_TOK = 4;
   localparam logic [7:0] DIAG_RESET       = 8'h00;
   localparam int         SHORT_PKT_LIMIT  = 254;
endpackage

// file: hdl/tncd_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tncd_cmd_if;
   logic       strobe;
   logic [7:0] code;
   modport src (output strobe, output code);
   modport dst (input strobe, input code);
endinterface
`default_nettype wire

// file: hdl/tncd_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tncd_cmd_decode (
   tncd_cmd_if.dst   cmd,
   output wire logic is_cancel_send,
   output wire logic is_cancel_listen,
   output wire logic is_arm_send,
   output wire logic is_arm_listen,
   output wire logic is_pkt_len,
   output wire logic is_flag_wipe,
   output wire logic is_chain_ack
);
   wire logic [2:0] op = cmd.code[tncd_pkg::OP_MSB:tncd_pkg::OP_LSB];
   wire logic       hi_zero = (cmd.code[7:5] == 3'h0);
   assign is_cancel_send   = cmd.strobe && cmd.code == tncd_pkg::CMD_CANCEL_SEND;
   assign is_cancel_listen = cmd.strobe && cmd.code == tncd_pkg::CMD_CANCEL_LISTN;
   assign is_arm_send      = cmd.strobe && hi_zero && op == tncd_pkg::OP_ARM_SEND;
   // broadcast bit lives in bit 7, so only bits 6:5 must be zero
   assign is_arm_listen    = cmd.strobe && cmd.code[6:5] == 2'h0
                             && op == tncd_pkg::OP_ARM_LISTEN;
   assign is_pkt_len       = cmd.strobe && cmd.code[7:4] == 4'h0
                             && op == tncd_pkg::OP_PKT_LEN;
   assign is_flag_wipe     = cmd.strobe && hi_zero && op == tncd_pkg::OP_FLAG_WIPE;
   assign is_chain_ack     = cmd.strobe && (cmd.code == tncd_pkg::CMD_CHAIN_TX_ACK
                             || cmd.code == tncd_pkg::CMD_CHAIN_RX_ACK);
endmodule
`default_nettype wire

// file: testbench/tncd_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the protocol engine: passes the token, then runs a short transmit
module tncd_engine_model (
   input  wire logic clock,
   input  wire logic go,
   input  wire logic ack_en,
   input  wire logic tx_pending,
   output logic      token_received,
   output logic      tx_ack_received,
   output logic      tx_done
);
   logic [3:0] cnt_q  = 4'h0;
   logic       busy_q = 1'b0;
   always_ff @(posedge clock) begin
      token_received  <= go;
      tx_ack_received <= 1'b0;
      tx_done         <= 1'b0;
      if (go && tx_pending) begin
         busy_q <= 1'b1;
         cnt_q  <= 4'h0;
      end else if (busy_q) begin
         cnt_q           <= cnt_q + 4'h1;
         // ack withheld on request to mimic a reply lost on the line
         tx_ack_received <= ack_en && cnt_q == 4'h2;
         tx_done         <= cnt_q == 4'h5;
         busy_q          <= cnt_q != 4'h5;
      end
   end
endmodule
`default_nettype wire

// file: testbench/tncd_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tncd_core_chk (
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       soft_rst,
   input wire logic       cmd_wr,
   input wire logic [7:0] cmd_data,
   input wire logic       diag_rd,
   input wire logic [7:0] diag_data,
   input wire logic       line_input,
   input wire logic       token_timer_expired,
   input wire logic       line_idle_expired,
   input wire logic       foreign_token_seen,
   input wire logic [7:0] rx_dest_id,
   input wire logic       tx_pending,
   input wire logic       tx_free_flag,
   input wire logic       tx_acked_flag,
   input wire logic       rx_enabled,
   input wire logic       rx_accept,
   input wire logic       accept_broadcast,
   input wire logic       long_packets,
   input wire logic       rx_inhibited_flag,
   input wire logic       power_up_flag,
   input wire logic       net_rebuild_flag
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst || soft_rst);
   logic      line_q;
   wire logic arm_tx = cmd_wr && cmd_data[7:5] == 3'h0 && cmd_data[2:0] == 3'h3;
   wire logic arm_rx = cmd_wr && cmd_data[6:5] == 2'h0 && cmd_data[2:0] == 3'h4;
   wire logic len_c  = cmd_wr && cmd_data[7:4] == 4'h0 && cmd_data[2:0] == 3'h5;
   wire logic wipe_c = cmd_wr && cmd_data[7:5] == 3'h0 && cmd_data[2:0] == 3'h6;
   // no event of any diagnostic source in this cycle
   wire logic quiet  = !token_timer_expired && !foreign_token_seen && line_input == line_q;
   always_ff @(posedge clock) line_q <= line_input;
   property p_arm; arm_tx |=> tx_pending && !tx_free_flag && !tx_acked_flag; endproperty
   a_arm: assert property (p_arm) else $error("arm send flags wrong");
   property p_listen;
      arm_rx |=> rx_enabled && !rx_inhibited_flag && accept_broadcast == $past(cmd_data[7]);
   endproperty
   a_listen: assert property (p_listen) else $error("arm listen flags wrong");
   property p_accept;
      rx_accept == (rx_enabled && (rx_dest_id != 8'h00 || accept_broadcast));
   endproperty
   a_accept: assert property (p_accept) else $error("packet accept wrong");
   property p_len; len_c |=> long_packets == $past(cmd_data[3]); endproperty
   a_len: assert property (p_len) else $error("length mode wrong");
   property p_wipe;
      wipe_c && !line_idle_expired |=> !(power_up_flag && $past(cmd_data[3]))
         && !(net_rebuild_flag && $past(cmd_data[4]));
   endproperty
   a_wipe: assert property (p_wipe) else $error("flag wipe wrong");
   property p_idle; line_idle_expired |=> net_rebuild_flag; endproperty
   a_idle: assert property (p_idle) else $error("rebuild flag not set");
   property p_clear;
      diag_rd && quiet ##1 !diag_rd && quiet ##1 diag_rd && quiet |=> diag_data == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("diag not cleared by read");
   property p_seen;
      foreign_token_seen ##1 !diag_rd ##1 diag_rd |=> diag_data[4] && !diag_data[6]
         && diag_data[3:0] == 4'h0;
   endproperty
   a_seen: assert property (p_seen) else $error("token seen bit wrong");
   c_tx: cover property (arm_tx ##[1:40] tx_free_flag && tx_acked_flag);
   c_bcast: cover property (rx_accept && rx_dest_id == 8'h00);
   c_wipe: cover property (net_rebuild_flag ##1 !net_rebuild_flag);
endmodule
bind tncd_core tncd_core_chk u_tncd_core_chk (.*);
`default_nettype wire

// file: testbench/token_net_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module token_net_command_decoder_tb;
   logic       clock = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, cmd_wr = 1'b0, diag_rd = 1'b0;
   logic       line_input = 1'b0, rx_in_progress = 1'b0, go = 1'b0, ack_en = 1'b0;
   logic [7:0] cmd_data = 8'h00, rx_dest_id = 8'h00, diag_data;
   logic [3:0] ev = 4'h0;
   logic [1:0] tx_page, rx_page;
   logic       token_received, tx_done, tx_ack_received, tx_pending, rx_enabled, rx_accept;
   logic       accept_broadcast, long_packets, tx_free_flag, tx_acked_flag;
   logic       rx_inhibited_flag, power_up_flag, net_rebuild_flag;
   int         fails = 0, cmp_count = 0;
   wire logic  token_timer_expired = ev[0], line_idle_expired = ev[1];
   wire logic  foreign_token_seen = ev[2], rx_good = ev[3];
   wire logic [7:0] flg = {tx_pending, tx_page, tx_free_flag, tx_acked_flag,
                           rx_inhibited_flag, power_up_flag, net_rebuild_flag};
   wire logic [7:0] rxv = {rx_enabled, rx_page, rx_accept, accept_broadcast, long_packets, 2'h0};
   tncd_core u_tncd_core (.*);
   tncd_engine_model u_tncd_engine_model (.*);
   initial forever #20 clock = ~clock;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // only defined codes go out, chain ack codes never
   task automatic cmd(input logic [7:0] c);
      @(posedge clock) cmd_wr <= 1'b1;
      cmd_data <= c;
      @(posedge clock) cmd_wr <= 1'b0;
      @(negedge clock);
   endtask
   task automatic pulse(input int i);
      @(posedge clock) ev <= 4'h1 << i;
      @(posedge clock) ev <= 4'h0;
      @(negedge clock);
   endtask
   task automatic rd(input logic [7:0] e);
      @(posedge clock) diag_rd <= 1'b1;
      @(posedge clock) diag_rd <= 1'b0;
      @(negedge clock) chk(diag_data, e);
   endtask
   task automatic token();
      @(posedge clock) go <= 1'b1;
      @(posedge clock) go <= 1'b0;
      repeat (3) @(negedge clock);
   endtask
   task automatic wait_free();
      for (int n = 0; n < 40; n++) begin
         @(negedge clock);
         if (tx_free_flag === 1'b1) return;
      end
      fails++;
      conclude();
   endtask
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock) chk(flg, 8'h16);
      rd(8'h00);
      @(posedge clock) ack_en <= 1'b1;
      cmd(8'h1b);
      chk(flg, 8'he6);
      token();
      wait_free();
      chk({3'h0, flg[4:0]}, 8'h1e);
      @(posedge clock) ack_en <= 1'b0;
      cmd(8'h0b);
      chk(flg, 8'ha6);
      token();
      wait_free();
      chk({3'h0, flg[4:0]}, 8'h16);
      cmd(8'h03);
      cmd(8'h01);
      chk(flg, 8'h06);
      token();
      chk(flg, 8'h16);
      cmd(8'h94);
      chk(rxv, 8'hd8);
      chk(flg, 8'h12);
      cmd(8'h0c);
      chk(rxv, 8'ha0);
      @(posedge clock) rx_dest_id <= 8'h05;
      @(negedge clock) chk(rxv, 8'hb0);
      pulse(3);
      chk(rxv, 8'h20);
      cmd(8'h04);
      @(posedge clock) rx_in_progress <= 1'b1;
      cmd(8'h02);
      token();
      chk(flg, 8'h12);
      @(posedge clock) rx_in_progress <= 1'b0;
      token();
      chk(flg, 8'h16);
      for (int c = 1; c >= 0; c--) begin
         cmd({4'h0, c[0], 3'h5});
         chk({7'h0, long_packets}, {7'h0, c[0]});
      end
      pulse(1);
      chk(flg, 8'h17);
      cmd(8'h0e);
      chk(flg, 8'h15);
      cmd(8'h16);
      chk(flg, 8'h14);
      @(posedge clock) line_input <= 1'b1;
      pulse(2);
      rd(8'h30);
      pulse(0);
      rd(8'h80);
      rd(8'h00);
      pulse(0);
      @(posedge clock) soft_rst <= 1'b1;
      @(posedge clock) soft_rst <= 1'b0;
      @(negedge clock) chk(flg, 8'h16);
      rd(8'h00);
      pulse(1);
      cmd(8'h1e);
      chk(flg, 8'h14);
      conclude();
   end
endmodule
`default_nettype wire
